// [src/cotr_consts.vh]
// constants for the converter offset trim register bank
// How it works
// - core two uses core2_input_a_offset[11:0] while sampling input pair A.
// - core two uses core2_input_b_offset[11:0] while sampling input pair B.
// - core three uses core3_input_c_offset[11:0] while sampling pair C.
// - core three uses core3_input_d_offset[11:0] while sampling pair D.
// - core four always uses core4_offset[11:0], regardless of input selection.
// - each trim register loads its default from fuse storage.
// - every trim field is treated as unsigned.
`ifndef COTR_CONSTS_VH
`define COTR_CONSTS_VH
`define COTR_IDX_2A     12'h334
`define COTR_IDX_2B     12'h336
`define COTR_IDX_3C     12'h338
`define COTR_IDX_3D     12'h33A
`define COTR_IDX_4      12'h33C
`define COTR_ADDR_2A    14'h0CD0
`define COTR_ADDR_2B    14'h0CD8
`define COTR_ADDR_3C    14'h0CE0
`define COTR_ADDR_3D    14'h0CE8
`define COTR_ADDR_4     14'h0CF0
`define COTR_ADDR_STAT  14'h0CF4
`define COTR_REG_W      16
`define COTR_TRIM_W     12
`define COTR_RESET_VAL  16'h0000
`define COTR_NREGS      5
`endif

// [src/cotr_fuse_load.v]
// one-shot fuse default loader for the trim registers
`timescale 1ns/100ps
`default_nettype none
module cotr_fuse_load (
  input  wire        hclk,      // clock
  input  wire        hresetn,   // async reset, low
  input  wire        fuse_valid_sync, // synchronised fuse ready level
  output reg         load_pulse, // one-cycle load strobe
  output reg         loaded      // defaults taken
);
  localparam ST_WAIT = 1'b0;
  localparam ST_DONE = 1'b1;
  reg state;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= ST_WAIT;
      load_pulse <= 1'b0;
      loaded     <= 1'b0;
    end else begin
      load_pulse <= 1'b0;
      case (state)
        ST_WAIT: begin
          if (fuse_valid_sync) begin
            load_pulse <= 1'b1;
            loaded     <= 1'b1;
            state      <= ST_DONE;
          end
        end
        ST_DONE: state <= ST_DONE;
        default: state <= ST_WAIT;
      endcase
    end
  end
endmodule
`default_nettype wire

// [src/cotr_regs.v]
// offset trim register bank with AHB-Lite slave and per-core selection
`timescale 1ns/100ps
`default_nettype none
`include "cotr_consts.vh"
module cotr_regs (
  input  wire        hclk,        // bus clock
  input  wire        hresetn,     // async reset, low
  input  wire        hsel,        // slave select
  input  wire [31:0] haddr,       // byte address
  input  wire [1:0]  htrans,      // transfer type
  input  wire        hwrite,      // write when high
  input  wire [2:0]  hsize,       // transfer size
  input  wire        hready,      // bus ready in
  input  wire [31:0] hwdata,      // write data
  output reg  [31:0] hrdata,      // read data
  output reg         hreadyout,   // slave ready
  output reg         hresp,       // always OKAY
  input  wire [79:0] fuse_defaults, // 5x16 fuse words, 2A,2B,3C,3D,4
  input  wire        fuse_valid,  // fuse storage ready (async)
  input  wire        core2_sel_b, // core two samples pair B (async)
  input  wire        core3_sel_d, // core three samples pair D (async)
  output reg  [11:0] core2_trim,  // applied offset, core two
  output reg  [11:0] core3_trim,  // applied offset, core three
  output reg  [11:0] core4_trim   // applied offset, core four
);
  reg  [15:0] trim [0:`COTR_NREGS-1];
  reg  [1:0]  fv_s;
  reg  [1:0]  s2_s;
  reg  [1:0]  s3_s;
  reg         dp_wr;
  reg  [2:0]  dp_idx;
  wire        load_pulse;
  wire        loaded;
  wire        ap_valid;
  wire [2:0]  ap_idx;
  genvar      g;

  // map byte address to register slot, 5 = status, 7 = unmapped
  function [2:0] addr_idx;
    input [13:0] a;
    begin
      case (a)
        `COTR_ADDR_2A:   addr_idx = 3'h0;
        `COTR_ADDR_2B:   addr_idx = 3'h1;
        `COTR_ADDR_3C:   addr_idx = 3'h2;
        `COTR_ADDR_3D:   addr_idx = 3'h3;
        `COTR_ADDR_4:    addr_idx = 3'h4;
        `COTR_ADDR_STAT: addr_idx = 3'h5;
        default:         addr_idx = 3'h7;
      endcase
    end
  endfunction

  assign ap_valid = hsel & htrans[1] & hready;
  assign ap_idx   = (haddr[31:14] == 18'h00000) ?
                    addr_idx(haddr[13:0]) : 3'h7;

  // two-flop synchronisers for pins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fv_s <= 2'b00;
      s2_s <= 2'b00;
      s3_s <= 2'b00;
    end else begin
      fv_s <= {fv_s[0], fuse_valid};
      s2_s <= {s2_s[0], core2_sel_b};
      s3_s <= {s3_s[0], core3_sel_d};
    end
  end

  cotr_fuse_load u_fuse (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .fuse_valid_sync (fv_s[1]),
    .load_pulse      (load_pulse),
    .loaded          (loaded)
  );

  // bus phase tracking, zero wait states
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr     <= 1'b0;
      dp_idx    <= 3'h7;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dp_wr     <= ap_valid & hwrite;
      dp_idx    <= ap_valid ? ap_idx : 3'h7;
      if (ap_valid && !hwrite) begin
        if (ap_idx < 3'h5)
          hrdata <= {16'h0000, trim[ap_idx]};
        else if (ap_idx == 3'h5)
          hrdata <= {31'h00000000, loaded};
        else
          hrdata <= 32'h00000000;
      end
    end
  end

  // trim storage: fuse load, then software writes of all 16 bits
  generate
    for (g = 0; g < `COTR_NREGS; g = g + 1) begin : gen_trim
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          trim[g] <= `COTR_RESET_VAL;
        end else if (dp_wr && dp_idx == g) begin
          trim[g] <= hwdata[15:0];
        end else if (load_pulse) begin
          trim[g] <= fuse_defaults[g*16 +: 16];
        end
      end
    end
  endgenerate

  // unsigned 12-bit offsets, routed per input selection for cores two and three, fixed for core four
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core2_trim <= 12'h000;
      core3_trim <= 12'h000;
      core4_trim <= 12'h000;
    end else begin
      if (s2_s[1])
        core2_trim <= trim[1][11:0];
      else
        core2_trim <= trim[0][11:0];
      if (s3_s[1])
        core3_trim <= trim[3][11:0];
      else
        core3_trim <= trim[2][11:0];
      core4_trim <= trim[4][11:0];
    end
  end
endmodule
`default_nettype wire

// [tb/cotr_regs_monitor.sv]
// assertions on the ports of the offset trim register bank
`timescale 1ns/100ps
`default_nettype none
module cotr_regs_monitor (
  input wire logic        hclk, hresetn, hsel, hwrite, hready, // bus
  input wire logic        hreadyout, hresp, fuse_valid,        // status
  input wire logic        core2_sel_b, core3_sel_d,            // selects
  input wire logic [31:0] haddr, hrdata,                       // bus
  input wire logic [1:0]  htrans,                              // bus
  input wire logic [79:0] fuse_defaults,                       // fuse words
  input wire logic [11:0] core2_trim, core3_trim, core4_trim   // trims
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd = hsel && htrans[1] && !hwrite && hready;
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or error");
  reset_clear_a: assert property ($rose(hresetn) |->
    hrdata == 32'h0 && core4_trim == 12'h0) else $error("reset value");
  upper_zero_a: assert property ($past(rd) |-> hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (rd && haddr[31:14] != 18'h0 |=>
    hrdata == 32'h0) else $error("unmapped read not zero");
  fuse_load_a: assert property ($rose(fuse_valid) && !core2_sel_b |->
    ##[3:8] core2_trim == fuse_defaults[11:0]) else $error("fuse load");
  core2_hold_a: assert property ((!hsel && $stable(core2_sel_b) &&
    $stable(fuse_valid))[*8] |=> $stable(core2_trim)) else $error("t2");
  core3_hold_a: assert property ((!hsel && $stable(core3_sel_d) &&
    $stable(fuse_valid))[*8] |=> $stable(core3_trim)) else $error("t3");
  core4_hold_a: assert property ((!hsel && $stable(fuse_valid))[*8]
    |=> $stable(core4_trim)) else $error("core four trim moved");
endmodule
bind cotr_regs cotr_regs_monitor cotr_regs_monitor_i (.hclk, .hresetn,
  .hsel, .hwrite, .hready, .hreadyout, .hresp, .fuse_valid, .core2_sel_b,
  .core3_sel_d, .haddr, .hrdata, .htrans, .fuse_defaults, .core2_trim,
  .core3_trim, .core4_trim);
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the offset trim register bank
`timescale 1ns/100ps
`default_nettype none
`include "cotr_consts.vh"
module tb;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fv = 0;
  logic        sb = 0, sd = 0;
  logic [31:0] haddr = 0, hwdata = 0, q;
  logic [1:0]  htrans = 0;
  logic [79:0] fz = 80'h1FFF_2A5C_3C3C_4001_0123;
  logic [13:0] ad [5] = '{`COTR_ADDR_2A, `COTR_ADDR_2B, `COTR_ADDR_3C,
                          `COTR_ADDR_3D, `COTR_ADDR_4};
  wire  [31:0] hrdata;
  wire         hready, hresp;
  wire  [11:0] t2, t3, t4;
  int          num_errors = 0, compares = 0, cyc = 0;
  cotr_regs cotr_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .fuse_defaults(fz), .fuse_valid(fv), .core2_sel_b(sb),
    .core3_sel_d(sd), .core2_trim(t2), .core3_trim(t3), .core4_trim(t4));
  always #20 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      results;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge hclk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'b10, w};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic t_reset_fuse;
    for (int i = 0; i < 5; i++) begin
      xfer(ad[i], 0, 0);
      chk("reset", q, 32'h0);
    end
    xfer(`COTR_ADDR_STAT, 0, 0);
    chk("status before fuse", q, 32'h0);
    fv <= 1;
    repeat (12) @(posedge hclk);
    for (int i = 0; i < 5; i++) begin
      xfer(ad[i], 0, 0);
      chk("fuse", q, {16'h0, fz[16*i +: 16]});
    end
    chk("t2 fuse", t2, fz[11:0]);
    chk("t4 fuse", t4, fz[75:64]);
    xfer(`COTR_ADDR_STAT, 0, 0);
    chk("status after fuse", q, 32'h1);
  endtask
  task automatic t_sel;
    // no calibration runs in this bench, so trim access is always legal
    for (int i = 0; i < 5; i++) xfer(ad[i], 1, 32'hABCD_0FF0 + i);
    for (int s = 0; s < 2; s++) begin
      sb <= s[0];
      sd <= s[0];
      repeat (6) @(posedge hclk);
      chk("t2", t2, 12'hFF0 + s);
      chk("t3", t3, 12'hFF2 + s);
      chk("t4", t4, 12'hFF4);
    end
    xfer(ad[3], 0, 0);
    chk("readback", q, 32'h0FF3);
    xfer(32'h0CF8, 0, 0);
    chk("unmapped", q, 32'h0);
    xfer(32'h0001_0CD0, 0, 0);
    chk("unmapped high", q, 32'h0);
  endtask
  task results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    t_reset_fuse;
    t_sel;
    results;
  end
endmodule
`default_nettype wire
